//--- bench/record_input_filter_control_tb.sv
// Self-checking bench for the record input filter block
module record_input_filter_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rifc_pkg::*;
	logic           clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, in_valid = 0;
	logic           stall = 0, slow = 0, rd_d = 0, in_ready, out_valid, out_ready;
	logic [7:0]     reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	rifc_frame_type in_frame = '0, out_frame, f, e;
	int             failures = 0, checked = 0;
	int             ca[4] = '{17, 34, 69, 137};
	int             cv[8] = '{129, 1287, 2574, 5147, 7721, 10294, 15441, 20588};
	logic [7:0]     rq[$];
	rifc_frame_type fq[$];
	always #12.5 clk = ~clk;
	rifc_top #(.RAMP_STEP(13'h0400), .BUF_DEPTH(2)) uut (.clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_ready, .in_frame, .out_valid,
		.out_ready, .out_frame);
	rifc_sink sink (.clk, .rstn, .stall, .slow, .out_ready);
	// ==========================================================
	// Helpers
	task automatic check(string what, logic [95:0] seen, logic [95:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	function automatic rifc_frame_type all4(logic [23:0] v);
		return {4{v}};
	endfunction
	task automatic do_reset();
		wait (fq.size() == 0);
		rstn <= 0;
		repeat (12) @(posedge clk);
		rstn <= 1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] x);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		rq.push_back(x);
		@(posedge clk);
		reg_rd <= 0;
	endtask
	task automatic send(rifc_frame_type v, rifc_frame_type x);
		@(posedge clk);
		in_valid <= 1;
		in_frame <= v;
		do @(posedge clk); while (!in_ready);
		in_valid <= 0;
		fq.push_back(x);
	endtask
	// ==========================================================
	// Result watcher
	always @(posedge clk) begin
		if (rd_d) check("reg_rdata", reg_rdata, rq.pop_front());
		if (out_valid && out_ready) check("out_frame", out_frame, fq.pop_front());
		rd_d <= reg_rd;
	end
	initial begin
		#(25ns * 20000);
		failures++;
		give_verdict();
	end
	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(25897));
		do_reset();
		rd(8'h18, 8'h00);
		rd(8'hBC, 8'h80);
		rd(8'hBD, 8'h80);
		rd(8'h55, 8'h00);
		wr(8'hBC, 8'h00);
		wr(8'hBD, 8'h00);
		for (int k = 0; k < 4; k++) wr(8'h18 + 8'(k), 8'h9F);
		rd(8'h1B, 8'h80);
		slow <= 1;
		repeat (16) begin
			f = {$urandom, $urandom, $urandom};
			send(f, f);
		end
		wr(8'h18, 8'hC0);
		wr(8'h19, 8'h00);
		e = f;
		e.chan[1:0] = '0;
		send(f, e);
		wait (fq.size() == 0);
		stall <= 1;
		send(f, e);
		send(f, e);
		@(posedge clk);
		check("in_ready", in_ready, 0);
		stall <= 0;
		do_reset();
		wr(8'hBC, 8'h00);
		wr(8'hBD, 8'h00);
		for (int k = 0; k < 4; k++) wr(8'h18 + 8'(k), 8'hA0);
		for (int k = 0; k < 6; k++) send(all4(24'h001000), all4(24'(k > 3 ? 4096 : k * 1024)));
		for (int k = 0; k < 4; k++) wr(8'h18 + 8'(k), 8'hE0);
		for (int k = 0; k < 6; k++) send(all4(24'h001000), all4(24'(k > 3 ? 0 : 4096 - k * 1024)));
		rd(8'h1C, 8'hF0);
		@(posedge clk);
		for (int c = 0; c < 8; c++) begin
			do_reset();
			for (int k = 0; k < 4; k++) wr(8'h18 + 8'(k), 8'h80);
			wr(8'hBC, 8'h80 | 8'(c % 4) << 4);
			wr(8'hBD, 8'h08 | 8'(c));
			rd(8'hBD, 8'h08 | 8'(c));
			send(all4(24'h010000), all4(24'h010000));
			e = all4(24'h010000 - 24'(cv[c]));
			e.chan[1:0] = {2{24'h010000 - 24'(ca[c % 4])}};
			send(all4(24'h010000), e);
		end
		wait (fq.size() == 0);
		give_verdict();
	end
endmodule
bind rifc_top rifc_checker #(.BUF_DEPTH(BUF_DEPTH)) chk (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame),
	.out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame));

//--- bench/rifc_checker.sv
// Port checker for the record input filter block
module rifc_checker
	import rifc_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input wire logic           clk,
	input wire logic           rstn,
	input wire logic [7:0]     reg_addr,
	input wire logic [7:0]     reg_wdata,
	input wire logic           reg_wr,
	input wire logic           reg_rd,
	input wire logic [7:0]     reg_rdata,
	input wire logic           in_valid,
	input wire logic           in_ready,
	input rifc_pkg::rifc_frame_type in_frame,
	input wire logic           out_valid,
	input wire logic           out_ready,
	input rifc_pkg::rifc_frame_type out_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Frames held in the buffer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) cnt <= 0;
		else cnt <= cnt + int'(in_valid && in_ready) - int'(out_valid && out_ready);
	end
	// ==========================================================
	// Register bus
	sequence s_chan_wr_rd;
		reg_wr && reg_addr inside {[8'h18:8'h1B]} ##1 !reg_wr
			##1 reg_rd && reg_addr == $past(reg_addr, 2);
	endsequence
	sequence s_hp_wr_rd;
		reg_wr && reg_addr inside {8'hBC, 8'hBD} ##1 !reg_wr
			##1 reg_rd && reg_addr == $past(reg_addr, 2);
	endsequence
	property p_chan_rd;
		s_chan_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hE0);
	endproperty
	a_chan_rd: assert property (p_chan_rd) else $error("channel readback wrong");
	property p_hp_rd;
		s_hp_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hBF);
	endproperty
	a_hp_rd: assert property (p_hp_rd) else $error("pair readback wrong");
	property p_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_unmapped;
		reg_rd && reg_addr inside {[8'h20:8'hBB]} |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// ==========================================================
	// Stream
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_frame);
	endproperty
	a_hold: assert property (p_hold) else $error("output frame dropped");
	property p_fast;
		in_valid && in_ready && cnt == 0 |=> out_valid;
	endproperty
	a_fast: assert property (p_fast) else $error("frame late");
	property p_full;
		in_ready == (cnt < BUF_DEPTH);
	endproperty
	a_full: assert property (p_full) else $error("in_ready wrong");
	property p_nonempty;
		out_valid == (cnt != 0);
	endproperty
	a_nonempty: assert property (p_nonempty) else $error("out_valid wrong");
endmodule

//--- bench/rifc_sink.sv
// Downstream mixer model: takes frames promptly, at random or not at all
module rifc_sink (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic stall,
	input  wire logic slow,
	output logic      out_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) out_ready <= 1'b0;
		else out_ready <= !stall && (!slow || 1'($urandom));
	end
endmodule

//--- hw/rifc_buf.sv
// Small valid/ready buffer held in flip-flops
module rifc_buf #(
	parameter int WIDTH = 96,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	import rifc_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	wire [PW-1:0] next_wr = (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
	wire [PW-1:0] next_rd = (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
	wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem    <= '{default: '0};
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				mem[wr_ptr] <= in_data;
			if (push)
				wr_ptr <= next_wr;
			if (pop)
				rd_ptr <= next_rd;
			count <= next_count;
		end
	end

endmodule

//--- hw/rifc_map.svh
// Register map, reset values, filter coefficients and gain constants
`ifndef RIFC_MAP_SVH
`define RIFC_MAP_SVH

// ==========================================================
// Register bus
`define RIFC_ADDR_W 8
`define RIFC_DATA_W 8
`define RIFC_OFS_P1_LEFT 8'h18
`define RIFC_OFS_P1_RIGHT 8'h19
`define RIFC_OFS_P2_LEFT 8'h1A
`define RIFC_OFS_P2_RIGHT 8'h1B
`define RIFC_OFS_STATUS 8'h1C
`define RIFC_OFS_P1_HP 8'hBC
`define RIFC_OFS_P2_HP 8'hBD
`define RIFC_CHAN_RESET 8'h00
`define RIFC_HP_RESET 8'h80
`define RIFC_READ_IDLE 8'h00

// ==========================================================
// Data path
`define RIFC_CHANS 4
`define RIFC_PAIRS 2
`define RIFC_SAMPLE_W 24
`define RIFC_ACC_W 28
`define RIFC_COEF_W 17
`define RIFC_COEF_SHIFT 16
`define RIFC_GAIN_W 13
`define RIFC_GAIN_SHIFT 12
`define RIFC_GAIN_ONE 13'h1000
`define RIFC_GAIN_ZERO 13'h0000
`define RIFC_RAMP_STEP 13'h0010

// ==========================================================
// Pole coefficients, Q16, 2*pi times corner over sample rate
`define RIFC_AUD_2HZ 17'h00011
`define RIFC_AUD_4HZ 17'h00022
`define RIFC_AUD_8HZ 17'h00045
`define RIFC_AUD_16HZ 17'h00089
`define RIFC_VOI_2P5HZ 17'h00081
`define RIFC_VOI_25HZ 17'h00507
`define RIFC_VOI_50HZ 17'h00A0E
`define RIFC_VOI_100HZ 17'h0141B
`define RIFC_VOI_150HZ 17'h01E29
`define RIFC_VOI_200HZ 17'h02836
`define RIFC_VOI_300HZ 17'h03C51
`define RIFC_VOI_400HZ 17'h0506C

`endif

//--- hw/rifc_pkg.sv
// Types shared by the record input filter control block
package rifc_pkg;
`include "rifc_map.svh"

	typedef logic signed [`RIFC_SAMPLE_W-1:0] rifc_sample_type;

	// Channel 0 pair 1 left, 1 pair 1 right, 2 pair 2 left, 3 pair 2 right
	typedef struct packed {
		logic [`RIFC_CHANS-1:0][`RIFC_SAMPLE_W-1:0] chan;
	} rifc_frame_type;

	typedef struct packed {
		logic       chan_on;
		logic       silence;
		logic       gain_glide;
		logic [4:0] reserved;
	} rifc_chan_ctrl_type;

	typedef struct packed {
		logic       hp_on;
		logic       reserved;
		logic [1:0] audio_corner;
		logic       voice_on;
		logic [2:0] voice_corner;
	} rifc_hp_ctrl_type;

endpackage

//--- hw/rifc_top.sv
// Record input filter control: four channels, two high-pass pairs
//
// Chosen here: the plain strobed port.
`include "rifc_map.svh"
// ==========================================================
// Function
// - Channel control bit 7 switches that filter channel on or off.
// - Channel control bit 6 set mutes the channel output.
// - Channel control bit 5 set enables gain ramping; clear applies gain at once.
// - Pair control bit 7 enables the audio high-pass; resets to enabled.
// - Audio corner bits 5:4 pick 2, 4, 8 or 16 Hz at 48 kHz.
// - Corners scale with sample rate through fixed rate-relative coefficients.
// - Pair control bit 3 enables the voice high-pass filter.
// - Voice corner bits 2:0 pick 2.5 to 400 Hz at 8 kHz.
module rifc_top
	import rifc_pkg::*;
#(
	parameter logic [`RIFC_GAIN_W-1:0] RAMP_STEP = `RIFC_RAMP_STEP,
	parameter int                      BUF_DEPTH = 2
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic [`RIFC_ADDR_W-1:0] reg_addr,
	input  wire logic [`RIFC_DATA_W-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [`RIFC_DATA_W-1:0]      reg_rdata,
	input  wire logic                    in_valid,
	output logic                         in_ready,
	input  rifc_pkg::rifc_frame_type     in_frame,
	output logic                         out_valid,
	input  wire logic                    out_ready,
	output rifc_pkg::rifc_frame_type     out_frame
);
	import rifc_pkg::*;

	localparam int SW = `RIFC_SAMPLE_W;
	localparam int AW = `RIFC_ACC_W;
	localparam int CW = `RIFC_COEF_W;
	localparam int GW = `RIFC_GAIN_W;
	localparam int NCH = `RIFC_CHANS;
	localparam int NPR = `RIFC_PAIRS;
	localparam int PRW = AW + CW + 1;
	localparam int GPW = SW + GW + 1;
	localparam int FW = $bits(rifc_frame_type);

	localparam logic [`RIFC_ADDR_W-1:0] CHAN_OFS [NCH] = '{
		`RIFC_OFS_P1_LEFT,
		`RIFC_OFS_P1_RIGHT,
		`RIFC_OFS_P2_LEFT,
		`RIFC_OFS_P2_RIGHT
	};
	localparam logic [`RIFC_ADDR_W-1:0] HP_OFS [NPR] = '{
		`RIFC_OFS_P1_HP,
		`RIFC_OFS_P2_HP
	};

	// ==========================================================
	// Helpers
	function automatic logic [CW-1:0] audio_coef(input logic [1:0] sel);
		logic [CW-1:0] c;
		c = `RIFC_AUD_2HZ;
		unique case (sel)
			2'h0: c = `RIFC_AUD_2HZ;
			2'h1: c = `RIFC_AUD_4HZ;
			2'h2: c = `RIFC_AUD_8HZ;
			2'h3: c = `RIFC_AUD_16HZ;
		endcase
		return c;
	endfunction

	function automatic logic [CW-1:0] voice_coef(input logic [2:0] sel);
		logic [CW-1:0] c;
		c = `RIFC_VOI_2P5HZ;
		unique case (sel)
			3'h0: c = `RIFC_VOI_2P5HZ;
			3'h1: c = `RIFC_VOI_25HZ;
			3'h2: c = `RIFC_VOI_50HZ;
			3'h3: c = `RIFC_VOI_100HZ;
			3'h4: c = `RIFC_VOI_150HZ;
			3'h5: c = `RIFC_VOI_200HZ;
			3'h6: c = `RIFC_VOI_300HZ;
			3'h7: c = `RIFC_VOI_400HZ;
		endcase
		return c;
	endfunction

	// Clamp an accumulator value into the sample range
	function automatic logic [SW-1:0] clamp(input logic [AW-1:0] v);
		logic [AW-SW:0] top;
		logic [SW-1:0]  r;
		top = v[AW-1:SW-1];
		if (&top || ~|top)
			r = v[SW-1:0];
		else if (v[AW-1])
			r = {1'b1, {(SW-1){1'b0}}};
		else
			r = {1'b0, {(SW-1){1'b1}}};
		return r;
	endfunction

	// ==========================================================
	// Registers
	rifc_chan_ctrl_type chan_reg [NCH];
	rifc_hp_ctrl_type   hp_reg [NPR];
	logic [NCH-1:0]     ramp_busy;
	logic [NCH-1:0]     chan_quiet;
	logic [GW-1:0]      gain [NCH];
	logic [GW-1:0]      target [NCH];

	wire [NCH-1:0] chan_hit;
	wire [NPR-1:0] hp_hit;
	wire           stat_hit = (reg_addr == `RIFC_OFS_STATUS);

	wire [`RIFC_DATA_W-1:0] chan_rd [NCH];
	wire [`RIFC_DATA_W-1:0] hp_rd [NPR];
	wire [`RIFC_DATA_W-1:0] stat_rd = {chan_quiet, ramp_busy};

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan_dec
			assign chan_hit[gi] = (reg_addr == CHAN_OFS[gi]);
			assign chan_rd[gi]  = {chan_reg[gi].chan_on,
				chan_reg[gi].silence, chan_reg[gi].gain_glide, 5'h00};
		end
		for (gi = 0; gi < NPR; gi++) begin : g_hp_dec
			assign hp_hit[gi] = (reg_addr == HP_OFS[gi]);
			assign hp_rd[gi]  = {hp_reg[gi].hp_on, 1'b0,
				hp_reg[gi].audio_corner, hp_reg[gi].voice_on,
				hp_reg[gi].voice_corner};
		end
	endgenerate

	wire [`RIFC_DATA_W-1:0] rd_value =
		chan_hit[0] ? chan_rd[0] :
		chan_hit[1] ? chan_rd[1] :
		chan_hit[2] ? chan_rd[2] :
		chan_hit[3] ? chan_rd[3] :
		hp_hit[0]   ? hp_rd[0] :
		hp_hit[1]   ? hp_rd[1] :
		stat_hit    ? stat_rd :
		`RIFC_READ_IDLE;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= `RIFC_READ_IDLE;
		else
			reg_rdata <= reg_rd ? rd_value : `RIFC_READ_IDLE;
	end

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan_reg
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					chan_reg[gi] <= rifc_chan_ctrl_type'(`RIFC_CHAN_RESET);
				else if (reg_wr && chan_hit[gi])
					chan_reg[gi] <= rifc_chan_ctrl_type'(reg_wdata);
			end
		end
		for (gi = 0; gi < NPR; gi++) begin : g_hp_reg
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					hp_reg[gi] <= rifc_hp_ctrl_type'(`RIFC_HP_RESET);
				else if (reg_wr && hp_hit[gi])
					hp_reg[gi] <= rifc_hp_ctrl_type'(reg_wdata);
			end
		end
	endgenerate

	// ==========================================================
	// Stream path
	wire            take = in_valid & in_ready;
	rifc_frame_type next_frame;

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_path
			localparam int PAIR = gi / 2;

			rifc_chan_ctrl_type ctl;
			rifc_hp_ctrl_type   hp;
			assign ctl = chan_reg[gi];
			assign hp  = hp_reg[PAIR];

			logic signed [AW-1:0] ax1;
			logic signed [AW-1:0] ay1;
			logic signed [AW-1:0] vx1;
			logic signed [AW-1:0] vy1;

			wire [CW-1:0] a_coef = audio_coef(hp.audio_corner);
			wire [CW-1:0] v_coef = voice_coef(hp.voice_corner);

			wire signed [SW-1:0] x = in_frame.chan[gi];
			wire signed [AW-1:0] x_ext = {{(AW-SW){x[SW-1]}}, x};

			// First-order high-pass, pole 1 - coef
			wire signed [PRW-1:0] a_prod = ay1 * $signed({1'b0, a_coef});
			wire signed [AW-1:0]  a_y =
				x_ext - ax1 + ay1 - AW'(a_prod >>> `RIFC_COEF_SHIFT);
			wire signed [SW-1:0]  s1 = hp.hp_on ? clamp(a_y) : x;
			wire signed [AW-1:0]  s1_ext = {{(AW-SW){s1[SW-1]}}, s1};

			wire signed [PRW-1:0] v_prod = vy1 * $signed({1'b0, v_coef});
			wire signed [AW-1:0]  v_y =
				s1_ext - vx1 + vy1 - AW'(v_prod >>> `RIFC_COEF_SHIFT);
			wire signed [SW-1:0]  s2 = hp.voice_on ? clamp(v_y) : s1;

			wire signed [GPW-1:0] g_prod = s2 * $signed({1'b0, gain[gi]});
			wire signed [AW-1:0]  g_y = AW'(g_prod >>> `RIFC_GAIN_SHIFT);

			assign next_frame.chan[gi] = ctl.chan_on ? clamp(g_y) : '0;

			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					ax1 <= '0;
					ay1 <= '0;
					vx1 <= '0;
					vy1 <= '0;
				end else if (take && !ctl.chan_on) begin
					ax1 <= '0;
					ay1 <= '0;
					vx1 <= '0;
					vy1 <= '0;
				end else if (take) begin
					ax1 <= x_ext;
					ay1 <= a_y;
					vx1 <= s1_ext;
					vy1 <= v_y;
				end
			end

			// Gain target and glide
			assign target[gi] = (ctl.chan_on && !ctl.silence) ?
				`RIFC_GAIN_ONE : `RIFC_GAIN_ZERO;

			wire [GW-1:0] up_room = target[gi] - gain[gi];
			wire [GW-1:0] dn_room = gain[gi] - target[gi];
			wire          raise = gain[gi] < target[gi];
			wire          lower = gain[gi] > target[gi];

			logic [GW-1:0] next_gain;
			always_comb begin
				next_gain = gain[gi];
				if (!ctl.gain_glide)
					next_gain = target[gi];
				else if (take && raise)
					next_gain = (up_room > RAMP_STEP) ?
						gain[gi] + RAMP_STEP : target[gi];
				else if (take && lower)
					next_gain = (dn_room > RAMP_STEP) ?
						gain[gi] - RAMP_STEP : target[gi];
			end

			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					gain[gi] <= `RIFC_GAIN_ZERO;
				else
					gain[gi] <= next_gain;
			end

			assign ramp_busy[gi]  = (gain[gi] != target[gi]);
			assign chan_quiet[gi] = (gain[gi] == `RIFC_GAIN_ZERO);
		end
	endgenerate

	// ==========================================================
	// Output buffer; a stalled receiver holds off the ADC side
	logic [FW-1:0] buf_out;

	rifc_buf #(
		.WIDTH (FW),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (next_frame),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (buf_out)
	);

	assign out_frame = rifc_frame_type'(buf_out);

endmodule
